// [verilog/das_regs_pkg.sv]
package das_regs_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int NUM_INSTR = 8;
    localparam int INDEX_W = 3;
    localparam int QUEUE_DEPTH = 32;
    localparam int QUEUE_PTR_W = 5;
    localparam int QUEUE_CNT_W = 6;

    // register addresses
    localparam logic [3:0] ADDR_RAM_LAST = 4'h7;
    localparam logic [3:0] ADDR_CONFIG = 4'h8;
    localparam logic [3:0] ADDR_INT_ENABLE = 4'h9;
    localparam logic [3:0] ADDR_INT_STATUS = 4'ha;
    localparam logic [3:0] ADDR_TIMER = 4'hb;
    localparam logic [3:0] ADDR_QUEUE = 4'hc;
    localparam logic [3:0] ADDR_LIMIT_STATUS = 4'hd;

    // configuration_control fields
    localparam int CFG_START = 0;
    localparam int CFG_RESET = 1;
    localparam int CFG_AUTOZERO = 2;
    localparam int CFG_FULLCAL = 3;
    localparam int CFG_STANDBY = 4;
    localparam int CFG_RP_LO = 8;
    localparam int CFG_RP_HI = 9;
    localparam logic [15:0] CFG_STORED_MASK = 16'h0ff1;
    localparam logic [15:0] CONFIG_RESET_VAL = 16'h0000;

    // ram_section_pointer codes
    localparam logic [1:0] SECT_INSTR = 2'h0;
    localparam logic [1:0] SECT_LIMIT1 = 2'h1;
    localparam logic [1:0] SECT_LIMIT2 = 2'h2;

    // interrupt_enable fields
    localparam logic [15:0] IE_SRC_MASK = 16'h00bf;
    localparam int IE_INSTR_LO = 8;
    localparam int IE_INSTR_HI = 10;
    localparam int IE_COUNT_LO = 11;
    localparam int IE_COUNT_HI = 15;
    localparam logic [15:0] IE_RESET_VAL = 16'h0000;

    // interrupt source bit positions
    localparam int INT_WATCHDOG = 0;
    localparam int INT_INSTR = 1;
    localparam int INT_COUNT = 2;
    localparam int INT_AUTOZERO = 3;
    localparam int INT_FULLCAL = 4;
    localparam int INT_PAUSE = 5;
    localparam int INT_STANDBY = 7;

    localparam logic [15:0] TIMER_RESET_VAL = 16'h0000;

    // instruction section fields
    localparam int FLD_LOOP = 0;
    localparam int FLD_PAUSE = 1;
    localparam int FLD_MUXP_LO = 2;
    localparam int FLD_MUXP_HI = 4;
    localparam int FLD_MUXN_LO = 5;
    localparam int FLD_MUXN_HI = 7;
    localparam int FLD_SYNC = 8;
    localparam int FLD_TIMER = 9;
    localparam int FLD_RES8 = 10;
    localparam int FLD_WATCHDOG = 11;
    localparam int FLD_ACQ_LO = 12;
    localparam int FLD_ACQ_HI = 15;

    // limit section fields
    localparam int LIM_VALUE_HI = 7;
    localparam int LIM_SIGN = 8;
    localparam int LIM_DIR = 9;
endpackage : das_regs_pkg

// [verilog/result_queue.sv]
`timescale 1ns/1ns
module result_queue
    import das_regs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic [DATA_W-1:0] push_data_i,
    input wire logic pop_i,
    output logic [DATA_W-1:0] head_o,
    output logic [QUEUE_CNT_W-1:0] fill_o
);
    logic [DATA_W-1:0] mem_reg [QUEUE_DEPTH];
    logic [QUEUE_PTR_W-1:0] wr_ptr_reg;
    logic [QUEUE_PTR_W-1:0] rd_ptr_reg;
    logic [QUEUE_CNT_W-1:0] fill_reg;
    logic do_push;
    logic do_pop;

    // a full queue drops new results; an empty one ignores pops
    assign do_push = push_i && (fill_reg != QUEUE_CNT_W'(QUEUE_DEPTH));
    assign do_pop = pop_i && (fill_reg != '0);
    assign head_o = (fill_reg != '0) ? mem_reg[rd_ptr_reg] : '0;
    assign fill_o = fill_reg;

    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem_reg[wr_ptr_reg] <= push_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end else if (clear_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                fill_reg <= fill_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                fill_reg <= fill_reg - 1'b1;
            end
        end
    end
endmodule : result_queue

// [verilog/das_register_map.sv]
// Overview of operation
// - configuration writes start/stop, reset, standby, calibrate and pick the RAM section
// - enable register gates up to seven interrupt sources onto the request output
// - enable register count field raises data-ready once the queue holds that many
// - enable register index field raises an interrupt when the sequencer reaches it
// - interrupt status and limit status are read only and report causes
// - status bits set on their condition regardless of the enable bits
// - timer value is applied as a delay only for instructions with timer bit set
// - decode the 4-bit address into configuration, enable, status, timer, limits
// - conversion queue is read only, all 32 entries through address 1100
// - eight 48-bit instructions in three separately accessible 16-bit sections
// - instruction words at addresses 0000 to 0111, any access order
// - section pointer in configuration bits 9:8 selects instruction, limit one, two
// - instruction section holds channel, resolution, watchdog, timer, sync, pause, loop
// - limit-one section holds value, sign and above/below direction
// - limit-two section holds value, sign and above/below direction
// - every register is readable, and writable where allowed, over the register port
`timescale 1ns/1ns
module das_register_map
    import das_regs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic conv_valid_i,
    input wire logic [DATA_W-1:0] conv_data_i,
    input wire logic seq_arrive_i,
    input wire logic [INDEX_W-1:0] seq_index_i,
    input wire logic limit_hit_i,
    input wire logic limit_sel_i,
    input wire logic [INDEX_W-1:0] limit_index_i,
    input wire logic autozero_done_i,
    input wire logic fullcal_done_i,
    input wire logic pause_hit_i,
    input wire logic standby_done_i,
    input wire logic [INDEX_W-1:0] fetch_index_i,
    output logic seq_start_o,
    output logic soft_reset_o,
    output logic autozero_cal_o,
    output logic full_cal_o,
    output logic standby_o,
    output logic [DATA_W-1:0] config_o,
    output logic int_request_o,
    output logic [DATA_W-1:0] step_delay_o,
    output logic instr_loop_o,
    output logic instr_pause_o,
    output logic [2:0] instr_mux_pos_o,
    output logic [2:0] instr_mux_neg_o,
    output logic instr_sync_o,
    output logic instr_timer_o,
    output logic instr_res8_o,
    output logic instr_watchdog_o,
    output logic [3:0] instr_acq_o,
    output logic [7:0] limit1_value_o,
    output logic limit1_sign_o,
    output logic limit1_above_o,
    output logic [7:0] limit2_value_o,
    output logic limit2_sign_o,
    output logic limit2_above_o
);
    logic [DATA_W-1:0] instr_sect_reg [NUM_INSTR];
    logic [DATA_W-1:0] limit1_sect_reg [NUM_INSTR];
    logic [DATA_W-1:0] limit2_sect_reg [NUM_INSTR];
    logic [DATA_W-1:0] config_reg;
    logic [DATA_W-1:0] int_enable_reg;
    logic [DATA_W-1:0] int_status_reg;
    logic [DATA_W-1:0] int_status_next;
    logic [DATA_W-1:0] timer_reg;
    logic [DATA_W-1:0] limit_status_reg;
    logic [DATA_W-1:0] limit_status_next;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] queue_head;
    logic [QUEUE_CNT_W-1:0] queue_fill;
    logic [1:0] section_ptr;
    logic [4:0] count_thresh;
    logic [INDEX_W-1:0] instr_addr;
    logic is_ram;
    logic wr_ram;
    logic wr_config;
    logic soft_reset_req;
    logic queue_pop;
    logic count_hit;
    logic [DATA_W-1:0] events;
    logic [DATA_W-1:0] fetched_instr;

    // RAM words sit at 0000-0111; address bit 3 marks the register block
    assign is_ram = (reg_addr_i <= ADDR_RAM_LAST);
    assign instr_addr = reg_addr_i[INDEX_W-1:0];
    assign wr_ram = reg_wr_i && is_ram;
    assign wr_config = reg_wr_i && (reg_addr_i == ADDR_CONFIG);
    assign section_ptr = config_reg[CFG_RP_HI:CFG_RP_LO];
    assign soft_reset_req = wr_config && reg_wdata_i[CFG_RESET];
    assign count_thresh = int_enable_reg[IE_COUNT_HI:IE_COUNT_LO];
    assign queue_pop = reg_rd_i && (reg_addr_i == ADDR_QUEUE);
    assign fetched_instr = instr_sect_reg[fetch_index_i];

    // a threshold of zero stands for a completely full queue
    assign count_hit = (count_thresh == '0) ? (queue_fill == QUEUE_CNT_W'(QUEUE_DEPTH)) :
                       (queue_fill >= {1'b0, count_thresh});

    result_queue u_queue (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clear_i(soft_reset_req),
        .push_i(conv_valid_i),
        .push_data_i(conv_data_i),
        .pop_i(queue_pop),
        .head_o(queue_head),
        .fill_o(queue_fill)
    );

    // each section of each instruction is written on its own
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_INSTR; i++) begin
                instr_sect_reg[i] <= '0;
                limit1_sect_reg[i] <= '0;
                limit2_sect_reg[i] <= '0;
            end
        end else if (wr_ram) begin
            unique case (section_ptr)
                SECT_INSTR: instr_sect_reg[instr_addr] <= reg_wdata_i;
                SECT_LIMIT1: limit1_sect_reg[instr_addr] <= reg_wdata_i;
                SECT_LIMIT2: limit2_sect_reg[instr_addr] <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // reset and calibration bits act once and read back as zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_reg <= CONFIG_RESET_VAL;
        end else if (wr_config) begin
            config_reg <= reg_wdata_i & CFG_STORED_MASK;
            if (reg_wdata_i[CFG_RESET]) begin
                config_reg[CFG_START] <= 1'b0;
            end
        end else if (pause_hit_i) begin
            config_reg[CFG_START] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            soft_reset_o <= 1'b0;
            autozero_cal_o <= 1'b0;
            full_cal_o <= 1'b0;
        end else begin
            soft_reset_o <= soft_reset_req;
            autozero_cal_o <= wr_config && reg_wdata_i[CFG_AUTOZERO];
            full_cal_o <= wr_config && reg_wdata_i[CFG_FULLCAL];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_enable_reg <= IE_RESET_VAL;
            timer_reg <= TIMER_RESET_VAL;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ADDR_INT_ENABLE) begin
                int_enable_reg <= reg_wdata_i;
            end
            if (reg_addr_i == ADDR_TIMER) begin
                timer_reg <= reg_wdata_i;
            end
        end
    end

    // conditions set status whatever the enables say
    always_comb begin
        events = '0;
        events[INT_WATCHDOG] = limit_hit_i;
        events[INT_INSTR] = seq_arrive_i &&
                            (seq_index_i == int_enable_reg[IE_INSTR_HI:IE_INSTR_LO]);
        events[INT_COUNT] = count_hit;
        events[INT_AUTOZERO] = autozero_done_i;
        events[INT_FULLCAL] = fullcal_done_i;
        events[INT_PAUSE] = pause_hit_i;
        events[INT_STANDBY] = standby_done_i;
    end

    // reading a status register clears it, but a new event in that cycle wins
    always_comb begin
        int_status_next = int_status_reg;
        if (soft_reset_req || (reg_rd_i && reg_addr_i == ADDR_INT_STATUS)) begin
            int_status_next = '0;
        end
        int_status_next = int_status_next | (events & IE_SRC_MASK);
    end

    always_comb begin
        limit_status_next = limit_status_reg;
        if (soft_reset_req || (reg_rd_i && reg_addr_i == ADDR_LIMIT_STATUS)) begin
            limit_status_next = '0;
        end
        if (limit_hit_i) begin
            limit_status_next[{limit_sel_i, limit_index_i}] = 1'b1;
        end
    end

    // status registers take no write path at all
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_status_reg <= '0;
            limit_status_reg <= '0;
        end else begin
            int_status_reg <= int_status_next;
            limit_status_reg <= limit_status_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_request_o <= 1'b0;
        end else begin
            int_request_o <= |(int_status_reg & int_enable_reg & IE_SRC_MASK);
        end
    end

    always_comb begin
        rdata_next = '0;
        if (is_ram) begin
            unique case (section_ptr)
                SECT_INSTR: rdata_next = instr_sect_reg[instr_addr];
                SECT_LIMIT1: rdata_next = limit1_sect_reg[instr_addr];
                SECT_LIMIT2: rdata_next = limit2_sect_reg[instr_addr];
                default: rdata_next = '0;
            endcase
        end else begin
            unique case (reg_addr_i)
                ADDR_CONFIG: rdata_next = config_reg;
                ADDR_INT_ENABLE: rdata_next = int_enable_reg;
                ADDR_INT_STATUS: rdata_next = int_status_reg;
                ADDR_TIMER: rdata_next = timer_reg;
                ADDR_QUEUE: rdata_next = queue_head;
                ADDR_LIMIT_STATUS: rdata_next = limit_status_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_next;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_start_o <= 1'b0;
            standby_o <= 1'b0;
            config_o <= CONFIG_RESET_VAL;
        end else begin
            seq_start_o <= config_reg[CFG_START];
            standby_o <= config_reg[CFG_STANDBY];
            config_o <= config_reg;
        end
    end

    // decoded view of the instruction the sequencer is fetching
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            instr_loop_o <= 1'b0;
            instr_pause_o <= 1'b0;
            instr_mux_pos_o <= '0;
            instr_mux_neg_o <= '0;
            instr_sync_o <= 1'b0;
            instr_timer_o <= 1'b0;
            instr_res8_o <= 1'b0;
            instr_watchdog_o <= 1'b0;
            instr_acq_o <= '0;
            step_delay_o <= '0;
        end else begin
            instr_loop_o <= fetched_instr[FLD_LOOP];
            instr_pause_o <= fetched_instr[FLD_PAUSE];
            instr_mux_pos_o <= fetched_instr[FLD_MUXP_HI:FLD_MUXP_LO];
            instr_mux_neg_o <= fetched_instr[FLD_MUXN_HI:FLD_MUXN_LO];
            instr_sync_o <= fetched_instr[FLD_SYNC];
            instr_timer_o <= fetched_instr[FLD_TIMER];
            instr_res8_o <= fetched_instr[FLD_RES8];
            instr_watchdog_o <= fetched_instr[FLD_WATCHDOG];
            instr_acq_o <= fetched_instr[FLD_ACQ_HI:FLD_ACQ_LO];
            step_delay_o <= fetched_instr[FLD_TIMER] ? timer_reg : '0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            limit1_value_o <= '0;
            limit1_sign_o <= 1'b0;
            limit1_above_o <= 1'b0;
            limit2_value_o <= '0;
            limit2_sign_o <= 1'b0;
            limit2_above_o <= 1'b0;
        end else begin
            limit1_value_o <= limit1_sect_reg[fetch_index_i][LIM_VALUE_HI:0];
            limit1_sign_o <= limit1_sect_reg[fetch_index_i][LIM_SIGN];
            limit1_above_o <= limit1_sect_reg[fetch_index_i][LIM_DIR];
            limit2_value_o <= limit2_sect_reg[fetch_index_i][LIM_VALUE_HI:0];
            limit2_sign_o <= limit2_sect_reg[fetch_index_i][LIM_SIGN];
            limit2_above_o <= limit2_sect_reg[fetch_index_i][LIM_DIR];
        end
    end
endmodule : das_register_map

// [tb/das_register_map_assertions.sv]
`timescale 1ns/1ns
module das_register_map_checker
    import das_regs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic pause_hit_i,
    input wire logic seq_start_o,
    input wire logic soft_reset_o,
    input wire logic autozero_cal_o,
    input wire logic full_cal_o,
    input wire logic standby_o,
    input wire logic [DATA_W-1:0] config_o,
    input wire logic int_request_o,
    input wire logic [DATA_W-1:0] step_delay_o,
    input wire logic instr_timer_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    logic [DATA_W-1:0] ie_q;
    wire cfg_wr = reg_wr_i && reg_addr_i == ADDR_CONFIG;

    // shadow of the enable register, rebuilt from the writes seen at the port
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ie_q <= IE_RESET_VAL;
        end else if (reg_wr_i && reg_addr_i == ADDR_INT_ENABLE) begin
            ie_q <= reg_wdata_i;
        end
    end

    a_read_valid: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > ADDR_LIMIT_STATUS
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_config_store: assert property (cfg_wr && !reg_wdata_i[CFG_RESET]
        |-> ##2 config_o == ($past(reg_wdata_i, 2) & CFG_STORED_MASK))
        else $error("config not stored");
    a_soft_reset_pulse: assert property (cfg_wr && reg_wdata_i[CFG_RESET]
        |=> soft_reset_o) else $error("soft reset pulse missing");
    a_cal_pulses: assert property (cfg_wr |=> {full_cal_o, autozero_cal_o} ==
        $past(reg_wdata_i[CFG_FULLCAL:CFG_AUTOZERO])) else $error("calibration pulse wrong");
    a_standby_level: assert property (cfg_wr |-> ##2 standby_o ==
        $past(reg_wdata_i[CFG_STANDBY], 2)) else $error("standby level wrong");
    a_start_level: assert property (cfg_wr && !reg_wdata_i[CFG_RESET] |-> ##2
        seq_start_o == $past(reg_wdata_i[CFG_START], 2)) else $error("start output wrong");
    a_pause_stop: assert property (pause_hit_i && !cfg_wr |-> ##2 !seq_start_o)
        else $error("pause left sequencer running");
    a_pause_irq: assert property (pause_hit_i && !reg_wr_i ##1 ie_q[INT_PAUSE]
        |=> int_request_o) else $error("enabled pause gave no request");
    a_irq_masked: assert property (int_request_o |-> |($past(ie_q) & IE_SRC_MASK))
        else $error("request with all sources disabled");
    a_timer_gate: assert property (!instr_timer_o |-> step_delay_o == 16'h0000)
        else $error("delay without timer bit");

    c_pause_irq: cover property (pause_hit_i ##2 int_request_o);
    c_soft_reset: cover property (soft_reset_o);
    c_queue_read: cover property (reg_rd_i && reg_addr_i == ADDR_QUEUE ##1 |reg_rdata_o);
endmodule : das_register_map_checker

bind das_register_map das_register_map_checker i_checker (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .pause_hit_i(pause_hit_i), .seq_start_o(seq_start_o),
    .soft_reset_o(soft_reset_o), .autozero_cal_o(autozero_cal_o), .full_cal_o(full_cal_o),
    .standby_o(standby_o), .config_o(config_o), .int_request_o(int_request_o),
    .step_delay_o(step_delay_o), .instr_timer_o(instr_timer_o)
);

// [tb/das_host.sv]
`timescale 1ns/1ns
module das_host
    import das_regs_pkg::*;
#(
    parameter int SETTLE_CYCLES = 4
)
(
    input wire logic clk_sys_i,
    output logic [ADDR_W-1:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [DATA_W-1:0] reg_wdata_o,
    input wire logic [DATA_W-1:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 4'h0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_wr_o = 1'b0;
        // data no longer driven: show the inverse so stale data cannot pass
        reg_wdata_o = ~d;
    endtask : wr

    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_rd_o = 1'b0;
        d = reg_rdata_i;
    endtask : rd

    // stop the sequencer, pick the section and let the running step finish
    task halt(input logic [1:0] s);
        wr(ADDR_CONFIG, {6'h00, s, 8'h00});
        repeat (SETTLE_CYCLES) @(posedge clk_sys_i);
    endtask : halt

    task ram_wr(input logic [1:0] s, input logic [3:0] a, input logic [15:0] d);
        halt(s);
        wr(a, d);
        wr(ADDR_CONFIG, {6'h00, s, 8'h02});
    endtask : ram_wr

    task ram_rd(input logic [1:0] s, input logic [3:0] a, output logic [15:0] d);
        halt(s);
        rd(a, d);
        wr(ADDR_CONFIG, {6'h00, s, 8'h02});
    endtask : ram_rd
endmodule : das_host

// [tb/das_register_map_bench.sv]
`timescale 1ns/1ns
`define CHECK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module das_register_map_bench
    import das_regs_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [6:0] ev = 7'h00;
    logic [2:0] seq_index_i = 3'h0, limit_index_i = 3'h0, fetch_index_i = 3'h0;
    logic limit_sel_i = 1'b0;
    logic [15:0] conv_data_i = 16'h0000;
    logic [3:0] reg_addr_i, instr_acq_o;
    logic [15:0] reg_wdata_i, reg_rdata_o, config_o, step_delay_o, d, m, instr_word;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, int_request_o, seq_start_o, soft_reset_o;
    logic autozero_cal_o, full_cal_o, standby_o, instr_loop_o, instr_pause_o, instr_sync_o;
    logic instr_timer_o, instr_res8_o, instr_watchdog_o, l1s, l1a, l2s, l2a;
    logic [2:0] mux_p, mux_n;
    logic [7:0] l1v, l2v;
    int fail_count = 0;
    int checks = 0;

    always #5 clk_sys_i = ~clk_sys_i;
    assign instr_word = {instr_acq_o, instr_watchdog_o, instr_res8_o, instr_timer_o,
        instr_sync_o, mux_n, mux_p, instr_pause_o, instr_loop_o};

    das_host i_host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

    das_register_map i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .conv_valid_i(ev[0]),
        .conv_data_i(conv_data_i), .seq_arrive_i(ev[1]), .seq_index_i(seq_index_i),
        .limit_hit_i(ev[2]), .limit_sel_i(limit_sel_i), .limit_index_i(limit_index_i),
        .autozero_done_i(ev[3]), .fullcal_done_i(ev[4]), .pause_hit_i(ev[5]),
        .standby_done_i(ev[6]), .fetch_index_i(fetch_index_i), .seq_start_o(seq_start_o),
        .soft_reset_o(soft_reset_o), .autozero_cal_o(autozero_cal_o), .full_cal_o(full_cal_o),
        .standby_o(standby_o), .config_o(config_o), .int_request_o(int_request_o),
        .step_delay_o(step_delay_o), .instr_loop_o(instr_loop_o), .instr_pause_o(instr_pause_o),
        .instr_mux_pos_o(mux_p), .instr_mux_neg_o(mux_n), .instr_sync_o(instr_sync_o),
        .instr_timer_o(instr_timer_o), .instr_res8_o(instr_res8_o),
        .instr_watchdog_o(instr_watchdog_o), .instr_acq_o(instr_acq_o), .limit1_value_o(l1v),
        .limit1_sign_o(l1s), .limit1_above_o(l1a), .limit2_value_o(l2v), .limit2_sign_o(l2s),
        .limit2_above_o(l2a));

    task automatic pulse(input logic [6:0] e);
        @(posedge clk_sys_i);
        #1;
        ev = e;
        @(posedge clk_sys_i);
        #1;
        ev = 7'h00;
    endtask : pulse

    task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string n);
        logic [15:0] v;
        i_host.rd(a, v);
        `CHECK(n, e, v)
    endtask : rchk

    function automatic logic [15:0] pat(input int s, input int a);
        return 16'((a * 32'h0e35) ^ (s * 32'h1111) ^ 32'h3c5a);
    endfunction : pat

    task end_sim;
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        #100000;
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        for (int a = 8; a < 16; a++) begin
            rchk(4'(a), 16'h0000, "reset value");
        end
        i_host.wr(ADDR_INT_ENABLE, 16'h1a25);
        rchk(ADDR_INT_ENABLE, 16'h1a25, "int enable");
        i_host.wr(ADDR_TIMER, 16'h1234);
        rchk(ADDR_TIMER, 16'h1234, "timer");
        i_host.wr(ADDR_CONFIG, 16'hffff);
        rchk(ADDR_CONFIG, 16'h0ff0, "config");
        `CHECK("standby", 1'b1, standby_o)
        i_host.wr(ADDR_CONFIG, 16'h0001);
        rchk(ADDR_CONFIG, 16'h0001, "config start");
        `CHECK("start", 1'b1, seq_start_o)
        pulse(7'h20);
        rchk(ADDR_INT_STATUS, 16'h0020, "pause status");
        `CHECK("start after pause", 1'b0, seq_start_o)
        `CHECK("pause irq", 1'b1, int_request_o)
        seq_index_i = 3'h2;
        pulse(7'h5a);
        rchk(ADDR_INT_STATUS, 16'h009a, "status set");
        `CHECK("masked irq", 1'b0, int_request_o)
        seq_index_i = 3'h3;
        pulse(7'h02);
        rchk(ADDR_INT_STATUS, 16'h0000, "index mismatch");
        for (int i = 0; i < 33; i++) begin
            conv_data_i = 16'ha000 + 16'(i);
            pulse(7'h01);
            if (i == 1) rchk(ADDR_INT_STATUS, 16'h0000, "below count");
            if (i == 2) rchk(ADDR_INT_STATUS, 16'h0004, "count hit");
            if (i == 2) `CHECK("count irq", 1'b1, int_request_o)
        end
        for (int i = 0; i < 33; i++) begin
            rchk(ADDR_QUEUE, i < 32 ? 16'ha000 + 16'(i) : 16'h0000, "queue");
        end
        rchk(ADDR_INT_STATUS, 16'h0004, "count sticky");
        rchk(ADDR_INT_STATUS, 16'h0000, "count gone");
        limit_sel_i = 1'b1;
        limit_index_i = 3'h5;
        pulse(7'h04);
        rchk(ADDR_LIMIT_STATUS, 16'h2000, "limit status");
        `CHECK("watchdog irq", 1'b1, int_request_o)
        rchk(ADDR_INT_STATUS, 16'h0001, "watchdog status");
        rchk(ADDR_LIMIT_STATUS, 16'h0000, "limit cleared");
        pulse(7'h40);
        i_host.wr(ADDR_INT_STATUS, 16'hffff);
        i_host.wr(ADDR_QUEUE, 16'hffff);
        i_host.wr(ADDR_LIMIT_STATUS, 16'hffff);
        rchk(ADDR_LIMIT_STATUS, 16'h0000, "limit read only");
        rchk(ADDR_QUEUE, 16'h0000, "queue read only");
        rchk(ADDR_INT_STATUS, 16'h0080, "status read only");
        pulse(7'h40);
        i_host.wr(ADDR_CONFIG, 16'h0002);
        rchk(ADDR_INT_STATUS, 16'h0000, "soft reset");
        for (int s = 0; s < 4; s++) begin
            for (int a = 7; a >= 0; a--) begin
                i_host.ram_wr(2'(s), 4'(a), s == 3 ? 16'hffff : pat(s, a));
            end
        end
        for (int s = 0; s < 4; s++) begin
            m = (s == 0) ? 16'hffff : 16'h03ff;
            for (int a = 0; a < 8; a++) begin
                i_host.ram_rd(2'(s), 4'(a), d);
                `CHECK("ram word", s == 3 ? 16'h0000 : pat(s, a) & m, d & m)
            end
        end
        for (int a = 0; a < 8; a++) begin
            fetch_index_i = 3'(a);
            @(posedge clk_sys_i);
            #1;
            `CHECK("instr fields", pat(0, a), instr_word)
            `CHECK("limit one", 10'(pat(1, a)), {l1a, l1s, l1v})
            `CHECK("limit two", 10'(pat(2, a)), {l2a, l2s, l2v})
            `CHECK("delay", pat(0, a) & 16'h0200 ? 16'h1234 : 16'h0000, step_delay_o)
        end
        end_sim();
    end
endmodule : das_register_map_bench
